// ==== hw/rxeb_pkg.sv ====
`default_nettype none

package rxeb_pkg;

  // ==========================================================================
  // Store geometry
  localparam int EB_DEPTH       = 32;
  localparam int EB_DATA_W      = 64;
  localparam int EB_CTRL_W      = 8;
  localparam int EB_CC_PER_WORD = 2;

  // ==========================================================================
  // Code words of the 64-bit, 8-lane stream
  localparam logic [EB_DATA_W-1:0] EB_IDLE_DATA = 64'h0707070707070707;
  localparam logic [EB_CTRL_W-1:0] EB_IDLE_CTRL = 8'hFF;
  localparam logic [EB_DATA_W-1:0] EB_LF_DATA   = 64'h0100009C0100009C;
  localparam logic [EB_CTRL_W-1:0] EB_LF_CTRL   = 8'h11;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [EB_CTRL_W-1:0] ctrl;
    logic [EB_DATA_W-1:0] data;
  } rxeb_word_t;

  typedef enum logic [1:0] {
    RXEB_FILL = 2'b01,
    RXEB_RUN  = 2'b10
  } rxeb_state_t;

endpackage

`default_nettype wire

// ==== hw/rxeb_store.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Flip-flop word store, written on the link clock
module rxeb_store #(
  parameter int DEPTH = rxeb_pkg::EB_DEPTH
) (
  input  wire logic   wr_clk,
  rxeb_store_if.store s
);
  import rxeb_pkg::*;

  rxeb_word_t mem_q [DEPTH];

  // Write one entry per accepted word
  always_ff @(posedge wr_clk) begin
    if (s.wr_en) begin
      mem_q[s.wr_addr] <= s.wr_word;
    end
  end

  // Read by index; the entry is stable once the read side sees it
  assign s.rd_word = mem_q[s.rd_addr];

endmodule

`default_nettype wire

// ==== hw/rxeb_store_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Store access: write port on the link clock, read port on the core clock
interface rxeb_store_if #(
  parameter int ADDR_W = 5
);
  import rxeb_pkg::*;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  rxeb_word_t        wr_word;
  logic [ADDR_W-1:0] rd_addr;
  rxeb_word_t        rd_word;

  modport store  (input wr_en, input wr_addr, input wr_word, input rd_addr, output rd_word);
  modport writer (output wr_en, output wr_addr, output wr_word);
  modport reader (output rd_addr, input rd_word);
endinterface

`default_nettype wire

// ==== hw/rxeb_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two-flop synchroniser for a level or a gray-coded word
module rxeb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== hw/rxeb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Receive elastic buffer: link clock in, core clock out
module rxeb_top #(
  parameter int DEPTH = rxeb_pkg::EB_DEPTH
) (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                link_clk,
  input  wire logic [rxeb_pkg::EB_DATA_W-1:0]      link_data,
  input  wire logic [rxeb_pkg::EB_CTRL_W-1:0]      link_ctrl,
  input  wire logic                                link_valid,
  output logic      [rxeb_pkg::EB_DATA_W-1:0]      out_data,
  output logic      [rxeb_pkg::EB_CTRL_W-1:0]      out_ctrl,
  output logic      [$clog2(rxeb_pkg::EB_DEPTH):0] out_fill,
  output logic                                     out_running,
  output logic                                     out_cc_inserted,
  output logic                                     out_overflow
);
  import rxeb_pkg::*;

  // Pointers carry one wrap bit; they cross in gray code
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PTR_W  = ADDR_W + 1;

  // Pointer-width limits; half depth is the working point with margin both ways
  localparam logic [PTR_W-1:0] DEPTH_PT = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] HALF_PT  = PTR_W'(DEPTH / 2);
  localparam logic [PTR_W-1:0] ONE_PT   = PTR_W'(1);

  // ==========================================================================
  // Elaboration checks
  generate
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("rxeb_top: DEPTH must be a power of two of at least 4");
    end
    if (PTR_W != $bits(out_fill)) begin : g_bad_fill
      $error("rxeb_top: DEPTH must match the fill output width");
    end
  endgenerate

  // ==========================================================================
  // Helpers
  // Binary to gray
  function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary
  function automatic logic [PTR_W-1:0] to_bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Whole idle clock-correction word, all lanes idle control
  function automatic logic is_cc(input rxeb_word_t w);
    return (w.ctrl == EB_IDLE_CTRL) && (w.data == EB_IDLE_DATA);
  endfunction

  // ==========================================================================
  // Shared store
  rxeb_store_if #(.ADDR_W(ADDR_W)) st ();

  rxeb_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .wr_clk (link_clk),
    .s      (st.store)
  );

  // ==========================================================================
  // Link-side reset: asserted at once, released on the link clock
  logic link_rst_meta_q;
  logic link_rst_q;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      link_rst_meta_q <= 1'b1;
      link_rst_q      <= 1'b1;
    end else begin
      link_rst_meta_q <= 1'b0;
      link_rst_q      <= link_rst_meta_q;
    end
  end

  // ==========================================================================
  // Link-side write logic
  logic [PTR_W-1:0] wr_bin_q;
  logic [PTR_W-1:0] wr_gray_q;
  logic [PTR_W-1:0] rd_gray_link;
  logic [PTR_W-1:0] rd_bin_link;
  logic [PTR_W-1:0] wr_fill;
  logic             wr_full;
  logic             wr_drop_cc;
  logic             wr_go;
  logic             ovf_tgl_q;
  rxeb_word_t       in_word;
  // Read pointer in gray, driven on the core side
  logic [PTR_W-1:0] rd_gray_q;

  // Read pointer seen from the link side
  rxeb_sync2 #(
    .W (PTR_W)
  ) u_rd_sync (
    .clock (link_clk),
    .rst   (link_rst_q),
    .d     (rd_gray_q),
    .q     (rd_gray_link)
  );

  // Fill seen from the link side; the lagging read pointer over-counts
  assign in_word     = '{ctrl: link_ctrl, data: link_data};
  assign rd_bin_link = to_bin(rd_gray_link);
  assign wr_fill     = wr_bin_q - rd_bin_link;
  assign wr_full     = (wr_fill == DEPTH_PT);

  // Drop idle clock-correction words while above half
  assign wr_drop_cc = link_valid && is_cc(in_word) && (wr_fill > HALF_PT);
  assign wr_go      = link_valid && !wr_drop_cc && !wr_full;

  // Store port, write half
  assign st.wr_en   = wr_go;
  assign st.wr_addr = wr_bin_q[ADDR_W-1:0];
  assign st.wr_word = in_word;

  // Write pointer, binary and gray
  always_ff @(posedge link_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      wr_bin_q  <= '0;
      wr_gray_q <= '0;
    end else if (wr_go) begin
      wr_bin_q  <= wr_bin_q + ONE_PT;
      wr_gray_q <= to_gray(wr_bin_q + ONE_PT);
    end
  end

  // Lost word event, toggled for the crossing
  always_ff @(posedge link_clk or posedge link_rst_q) begin
    if (link_rst_q) begin
      ovf_tgl_q <= 1'b0;
    end else if (link_valid && !wr_drop_cc && wr_full) begin
      ovf_tgl_q <= ~ovf_tgl_q;
    end
  end

  // ==========================================================================
  // Core-side read logic
  rxeb_state_t      state_q;
  rxeb_state_t      state_d;
  logic [PTR_W-1:0] rd_bin_q;
  logic [PTR_W-1:0] rd_bin_d;
  logic [PTR_W-1:0] wr_gray_core;
  logic [PTR_W-1:0] wr_bin_core;
  logic [PTR_W-1:0] rd_fill;
  logic             rd_empty;
  logic             last_cc_q;
  logic             last_cc_d;
  logic             insert_d;
  rxeb_word_t       head;
  rxeb_word_t       out_d;

  // Write pointer seen from the core side
  rxeb_sync2 #(
    .W (PTR_W)
  ) u_wr_sync (
    .clock (clock),
    .rst   (rst),
    .d     (wr_gray_q),
    .q     (wr_gray_core)
  );

  // Fill seen from the core side; the lagging write pointer under-counts
  assign wr_bin_core = to_bin(wr_gray_core);
  assign rd_fill     = wr_bin_core - rd_bin_q;
  assign rd_empty    = (rd_fill == '0);

  // Store port, read half
  assign st.rd_addr = rd_bin_q[ADDR_W-1:0];
  assign head       = st.rd_word;

  // Choice of the next word sent
  always_comb begin
    state_d   = state_q;
    rd_bin_d  = rd_bin_q;
    last_cc_d = last_cc_q;
    insert_d  = 1'b0;
    out_d     = '{ctrl: EB_LF_CTRL, data: EB_LF_DATA};
    unique case (state_q)
      RXEB_FILL: begin
        // Hold off reading until half full
        last_cc_d = 1'b0;
        if (rd_fill >= HALF_PT) begin
          state_d = RXEB_RUN;
        end
      end
      RXEB_RUN: begin
        if (rd_empty) begin
          // Nothing valid: local fault and refill
          last_cc_d = 1'b0;
          state_d   = RXEB_FILL;
        end else if (last_cc_q && (rd_fill < HALF_PT)) begin
          // Repeat the idle word between frames
          out_d    = '{ctrl: EB_IDLE_CTRL, data: EB_IDLE_DATA};
          insert_d = 1'b1;
        end else begin
          // Deliver the oldest word; its age sets the latency
          out_d     = head;
          rd_bin_d  = rd_bin_q + ONE_PT;
          last_cc_d = is_cc(head);
        end
      end
    endcase
  end

  // Read state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= RXEB_FILL;
    end else begin
      state_q <= state_d;
    end
  end

  // Read pointer, binary and gray
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_bin_q  <= '0;
      rd_gray_q <= '0;
    end else begin
      rd_bin_q  <= rd_bin_d;
      rd_gray_q <= to_gray(rd_bin_d);
    end
  end

  // Last sent word was an idle word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_cc_q <= 1'b0;
    end else begin
      last_cc_q <= last_cc_d;
    end
  end

  // ==========================================================================
  // Core-side outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_data <= EB_LF_DATA;
      out_ctrl <= EB_LF_CTRL;
    end else begin
      out_data <= out_d.data;
      out_ctrl <= out_d.ctrl;
    end
  end

  // Status: fill level, run state, insertion pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_fill        <= '0;
      out_running     <= 1'b0;
      out_cc_inserted <= 1'b0;
    end else begin
      out_fill        <= rd_fill;
      out_running     <= (state_d == RXEB_RUN);
      out_cc_inserted <= insert_d;
    end
  end

  // ==========================================================================
  // Overflow event crossing into the core domain
  logic ovf_tgl_core;
  logic ovf_seen_q;

  rxeb_sync2 #(
    .W (1)
  ) u_ovf_sync (
    .clock (clock),
    .rst   (rst),
    .d     (ovf_tgl_q),
    .q     (ovf_tgl_core)
  );

  // One pulse per toggle seen
  // Two losses inside one core clock period cancel out and give no pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovf_seen_q   <= 1'b0;
      out_overflow <= 1'b0;
    end else begin
      ovf_seen_q   <= ovf_tgl_core;
      out_overflow <= ovf_tgl_core ^ ovf_seen_q;
    end
  end

endmodule

`default_nettype wire

// ==== verification/rxeb_link_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Receive decoder model: frames of numbered words between idle gaps
module rxeb_link_src (
  input  wire logic                           link_clk,
  input  wire logic                           rst,
  input  wire logic [1:0]                     mode,
  output logic      [rxeb_pkg::EB_DATA_W-1:0] link_data,
  output logic      [rxeb_pkg::EB_CTRL_W-1:0] link_ctrl,
  output logic                                link_valid
);
  import rxeb_pkg::*;
  integer seed;
  int     seq, left, gap, ph, hold;
  initial begin
    seed = 32'he00b;
    {seq, left, ph, hold} = '0;
    gap = 2;
    link_valid = 1'b0;
    link_data = '0;
    link_ctrl = '0;
  end

  // Mode 1: every 2nd edge, 2: every 3rd, 3: every edge, 0: none
  always @(negedge link_clk) begin
    ph = (ph + 1) % (mode == 2'd2 ? 3 : 2);
    if (rst) hold = 4;
    else if (hold > 0) hold = hold - 1;
    if (hold > 0 || mode == 2'd0 || (mode != 2'd3 && ph != 0)) begin
      link_valid <= 1'b0;
      link_data  <= ~link_data;  // Stale lanes never left standing
    end else if (gap > 0) begin
      gap = gap - 1;
      link_valid <= 1'b1;
      link_data  <= EB_IDLE_DATA;
      link_ctrl  <= EB_IDLE_CTRL;
      if (gap == 0) left = 1 + ($unsigned($random(seed)) % 4);
    end else begin
      seq = seq + 1;
      left = left - 1;
      link_valid <= 1'b1;
      link_data  <= {seq[31:0], ~seq[31:0]};
      link_ctrl  <= 8'h00;
      if (left == 0) gap = 1 + ($unsigned($random(seed)) % 3);
    end
  end
endmodule

`default_nettype wire

// ==== verification/rxeb_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Core-side output checks
module rxeb_top_asserts #(
  parameter int DEPTH = rxeb_pkg::EB_DEPTH
) (
  input wire logic                                clock,
  input wire logic                                rst,
  input wire logic [rxeb_pkg::EB_DATA_W-1:0]      out_data,
  input wire logic [rxeb_pkg::EB_CTRL_W-1:0]      out_ctrl,
  input wire logic [$clog2(rxeb_pkg::EB_DEPTH):0] out_fill,
  input wire logic                                out_running,
  input wire logic                                out_cc_inserted,
  input wire logic                                out_overflow
);
  import rxeb_pkg::*;
  localparam int HALF = DEPTH / 2;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Fault words and start-up
  AST_FILL_LF: assert property (!out_running |->
    out_data == EB_LF_DATA && out_ctrl == EB_LF_CTRL) else $error("no fault word outside run");
  AST_START_LF: assert property ($rose(out_running) |-> out_data == EB_LF_DATA)
    else $error("first run word not a fault word");
  AST_START_HALF: assert property ($rose(out_running) |-> out_fill >= HALF - 1)
    else $error("run started below half full");
  AST_RUN_HOLD: assert property ($rose(out_running) |-> out_running [*4])
    else $error("run dropped right after start");
  // Insertion
  AST_INS_IDLE: assert property (out_cc_inserted |->
    out_data == EB_IDLE_DATA && out_ctrl == EB_IDLE_CTRL) else $error("inserted word not idle");
  AST_INS_AFTER_IDLE: assert property (out_cc_inserted |->
    $past(out_ctrl) == EB_IDLE_CTRL && $past(out_data) == EB_IDLE_DATA)
    else $error("insertion not after idle");
  AST_INS_LOW: assert property (out_cc_inserted |-> out_running && out_fill <= HALF)
    else $error("insertion above half full");
  // Fill bounds
  AST_FILL_MAX: assert property (out_fill <= DEPTH)
    else $error("fill above depth");
  AST_OVF_FULL: assert property (out_overflow |-> out_fill >= DEPTH - 8)
    else $error("overflow while store not full");

  // Main scenarios
  CV_START: cover property ($rose(out_running));
  CV_INS: cover property (out_cc_inserted);
  CV_OVF: cover property (out_overflow);
endmodule

bind rxeb_top rxeb_top_asserts #(.DEPTH(DEPTH)) u_asserts (.clock(clock), .rst(rst),
  .out_data(out_data), .out_ctrl(out_ctrl), .out_fill(out_fill), .out_running(out_running),
  .out_cc_inserted(out_cc_inserted), .out_overflow(out_overflow));

`default_nettype wire

// ==== verification/rxeb_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Elastic buffer bench
module rxeb_top_tb;
  import rxeb_pkg::*;
  logic                 clock, rst, link_clk, link_valid, out_running, out_cc_inserted;
  logic                 out_overflow;
  logic [1:0]           mode;
  logic [EB_DATA_W-1:0] link_data, out_data;
  logic [EB_CTRL_W-1:0] link_ctrl, out_ctrl;
  logic [5:0]           out_fill;
  int                   n_mismatch, cmp_count, last, n_ins, n_ovf, max_fill;
  bit                   resync, lossy;

  rxeb_top dut (.clock(clock), .rst(rst), .link_clk(link_clk), .link_data(link_data),
    .link_ctrl(link_ctrl), .link_valid(link_valid), .out_data(out_data), .out_ctrl(out_ctrl),
    .out_fill(out_fill), .out_running(out_running), .out_cc_inserted(out_cc_inserted),
    .out_overflow(out_overflow));
  rxeb_link_src u_src (.link_clk(link_clk), .rst(rst), .mode(mode), .link_data(link_data),
    .link_ctrl(link_ctrl), .link_valid(link_valid));

  // Clocks, unrelated in phase
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  // Expected numbered frame word
  function automatic logic [63:0] data_word(int n);
    return {n[31:0], ~n[31:0]};
  endfunction

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (exp !== got) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_run();
    for (int i = 0; i < 400 && out_running !== 1'b1; i++) @(negedge clock);
    chk("out_running", 1, out_running);
  endtask

  // Output stream monitor: order kept, only idle or fault words besides data
  always @(negedge clock) begin
    if (!rst) begin
      if (out_ctrl === 8'h00) begin
        if (resync) begin
          last = int'(out_data[63:32]);
        end else if (lossy) begin
          chk("frame_order", 1, int'(out_data[63:32]) > last);
          last = int'(out_data[63:32]);
        end else begin
          chk("frame_word", data_word(last + 1), out_data);
          last = last + 1;
        end
        resync = 0;
      end else if (out_ctrl !== EB_IDLE_CTRL)
        chk("fault_word", EB_LF_DATA, out_data);
      else
        chk("idle_word", EB_IDLE_DATA, out_data);
      n_ins += (out_cc_inserted === 1'b1);
      n_ovf += (out_overflow === 1'b1);
      if (out_fill > max_fill) max_fill = out_fill;
    end
  end

  // Watchdog
  initial begin
    #(25.0 * 20000);
    n_mismatch++;
    finish_test();
  end

  // Main sequence
  initial begin
    {n_mismatch, cmp_count, last, n_ins, n_ovf, max_fill} = '0;
    resync = 0;
    lossy = 0;
    rst = 1'b1;
    mode = 2'd0;
    repeat (12) @(negedge clock);
    chk("out_data", EB_LF_DATA, out_data);
    chk("out_fill", 0, out_fill);
    rst = 1'b0;
    mode = 2'd1;
    repeat (5) @(negedge clock);
    chk("out_running", 0, out_running);
    wait_run();
    chk("fill_at_start", 1, out_fill >= EB_DEPTH / 2);
    repeat (2000) @(negedge clock);
    chk("overflows", 0, n_ovf);
    chk("fill_near_half", 1, max_fill <= 20);
    mode = 2'd2;
    repeat (2000) @(negedge clock);
    chk("insertions_seen", 1, n_ins > 0);
    lossy = 1;
    mode = 2'd3;
    repeat (300) @(negedge clock);
    chk("overflow_seen", 1, n_ovf > 0);
    chk("fill_peak", 1, max_fill >= 24);
    resync = 1;
    mode = 2'd1;
    repeat (500) @(negedge clock);
    rst = 1'b1;
    lossy = 0;
    repeat (4) @(negedge clock);
    chk("reset_data", EB_LF_DATA, out_data);
    chk("reset_fill", 0, out_fill);
    rst = 1'b0;
    resync = 1;
    wait_run();
    repeat (200) @(negedge clock);
    finish_test();
  end
endmodule

`default_nettype wire
